// ===== pkg/power_path_pkg.sv
// Purpose: shared constants and types for the bus power path control block
// Assumes: 40 MHz clock
// Notes:   attach states are a coded view of the connection state machine
`default_nettype none
package power_path_pkg;
  localparam int unsigned CLOCK_HZ           = 40_000_000;
  localparam int unsigned CABLE_DISCH_MS     = 250;
  localparam int unsigned CABLE_DISCH_CYCLES = CABLE_DISCH_MS * (CLOCK_HZ / 1000);
  localparam int unsigned BUS_DISCH_W        = 8;
  localparam int unsigned BUS_DISCH_UNIT_US  = 1000;  // one duration step
  localparam int unsigned BUS_DISCH_UNIT_CYC = BUS_DISCH_UNIT_US * (CLOCK_HZ / 1_000_000);
  localparam logic [7:0]  BUS_DISCH_DEFAULT  = 8'hC8;
  localparam logic        CABLE_UV_SEL_HIGH  = 1'b0;  // 0 = 4.65 V, 1 = 2.65 V
  localparam logic        CABLE_UV_SEL_LOW   = 1'b1;
  localparam int unsigned SYNC_STAGES        = 3;

  // connection states reported by the connection state machine
  typedef enum logic [3:0] {
    ST_UNATTACHED      = 4'h0,
    ST_ATTACHED_SRC    = 4'h1,
    ST_UNORIENT_DBG_SRC= 4'h2,
    ST_ORIENT_DBG_SRC  = 4'h3,
    ST_ATTACHED_SNK    = 4'h4,
    ST_DBG_SNK         = 4'h5,
    ST_ERROR_RECOVERY  = 4'h6,
    ST_ATTACH_WAIT     = 4'h7
  } conn_state_t;

  typedef enum logic [1:0] {
    ROLE_SOURCE = 2'b00,
    ROLE_SINK   = 2'b01,
    ROLE_DUAL   = 2'b10
  } power_role_t;

  typedef enum logic [1:0] {
    DS_IDLE   = 2'b00,
    DS_ACTIVE = 2'b01
  } disch_state_t;
endpackage
`default_nettype wire

// ===== pkg/discharge_if.sv
// Purpose: carries a discharge request and its status between modules
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, duration sampled on start
`default_nettype none
interface discharge_if;
  logic        start;
  logic        abort;
  logic [23:0] duration_cycles;
  logic        active;
  modport ctrl  (output start, output abort, output duration_cycles, input active);
  modport timer (input start, input abort, input duration_cycles, output active);
endinterface
`default_nettype wire

// ===== hdl/discharge_timer.sv
// Purpose: one-shot timer that holds a discharge path on for a set time
// Assumes: duration of at least one cycle
// Notes:   a new start while active restarts the count
`default_nettype none
module discharge_timer
  import power_path_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    nrst,
  input  wire logic    ce,
  discharge_if.timer   dif
);
  disch_state_t state_reg;
  logic [23:0]  count_reg;
  wire          count_done = (count_reg == 24'h00_0001);

  // restart wins over expiry so a fresh event is never lost
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= DS_IDLE;
      count_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        DS_IDLE: begin
          if (dif.start && dif.duration_cycles != '0) begin
            state_reg <= DS_ACTIVE;
            count_reg <= dif.duration_cycles;
          end
        end
        DS_ACTIVE: begin
          if (dif.start && dif.duration_cycles != '0) begin
            count_reg <= dif.duration_cycles;
          end else if (dif.abort || count_done) begin
            state_reg <= DS_IDLE;
            count_reg <= '0;
          end else begin
            count_reg <= count_reg - 24'h00_0001;
          end
        end
        default: state_reg <= DS_IDLE;
      endcase
    end
  end

  assign dif.active = (state_reg == DS_ACTIVE);

  a_timer_len: assert property (@(posedge clock) disable iff (!nrst)
    (ce && dif.active && !dif.start && !dif.abort && count_done) |=> !dif.active)
    else $error("discharge did not end when the count ran out");
endmodule
`default_nettype wire

// ===== hdl/power_path_control.sv
// Purpose: bus and cable power path enables and discharge control
// Assumes: state and comparator inputs from logic on this clock, except the
//          analog comparator pins which are synchronised here
// Notes:   enables are open drain: oe low drives the pin low
//
// Operation
// - bus discharge starts on detach and on error recovery entry, any role.
// - bus discharge enabled by default, disabled only by stored configuration.
// - discharge duration loads from stored default, software may overwrite.
// - source enable turns low only in attached source states with monitors valid.
// - supply above undervoltage and below overvoltage when those checks enabled.
// - source enable released otherwise or when the bus monitor becomes invalid.
// - supply under or over voltage, if checked, blocks source enable turn-on only.
// - sink enable low in attached sink states with bus voltage valid.
// - sink enable released outside those states or on invalid bus voltage.
// - attached source reached only with bus at safe zero volts.
// - supply checks apply only to source role, never to sink enable.
// - supply check enables from stored defaults, changeable by software.
// - once source enable asserted, supervision moves to bus sense.
// - bus check uses window by default, may fall back to undervoltage.
// - source enable held while attached and bus voltage stays valid.
// - cable supply only in source or dual role, on unwired pin.
// - cable supply needs switches on, sink attached, Ra seen, supply good.
// - cable supply never given in sink role.
// - cable undervoltage select defaults to 4.65 V, software may pick 2.65 V.
// - in source mode, if enabled, cable discharge for 250 ms after detach.
// - out-of-range bus after attach drops path; source errors, sink unattaches.
`default_nettype none
module power_path_control
  import power_path_pkg::*;
#(
  parameter int unsigned CABLE_DISCH_COUNT = CABLE_DISCH_CYCLES
)(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  input  wire power_path_pkg::conn_state_t conn_state,
  input  wire power_path_pkg::power_role_t power_role,
  input  wire logic                      cc_wire_is_cc2,
  input  wire logic                      supply_above_uv_pin,
  input  wire logic                      supply_above_ov_pin,
  input  wire logic                      bus_in_window_pin,
  input  wire logic                      bus_above_uv_pin,
  input  wire logic                      bus_safe_zero_pin,
  input  wire logic                      cable_supply_above_uv_pin,
  input  wire logic                      ra_on_unwired_pin,
  input  wire logic                      nvm_bus_disch_en,
  input  wire logic [7:0]                nvm_bus_disch_time,
  input  wire logic                      nvm_supply_uv_check,
  input  wire logic                      nvm_supply_ov_check,
  input  wire logic                      nvm_bus_window_check,
  input  wire logic                      nvm_cable_disch_en,
  input  wire logic                      sw_wr_disch_time,
  input  wire logic [7:0]                sw_disch_time,
  input  wire logic                      sw_wr_checks,
  input  wire logic                      sw_supply_uv_check,
  input  wire logic                      sw_supply_ov_check,
  input  wire logic                      sw_bus_window_check,
  input  wire logic                      sw_cable_disch_en,
  input  wire logic                      sw_cable_uv_sel,
  input  wire logic                      sw_wr_cable_uv_sel,
  input  wire logic                      cable_switch_en,
  output logic                           source_path_enable_n_out,
  output logic                           source_path_enable_n_oe,
  output logic                           sink_path_enable_n_out,
  output logic                           sink_path_enable_n_oe,
  output logic                           bus_discharge_on,
  output logic                           cable_supply_cc1,
  output logic                           cable_supply_cc2,
  output logic                           cable_discharge_on,
  output logic                           cable_uv_sel,
  output logic                           source_fault_to_recovery,
  output logic                           sink_fault_to_unattached,
  output logic                           source_attach_allowed
);
  import power_path_pkg::*;

  localparam int unsigned NPIN = 7;

  // three stage synchronisers; only stages two and three are looked at
  // a level is taken once stages two and three agree, so a one-cycle glitch is dropped
  // limitation: a comparator change reaches the enables about five enabled cycles late
  logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  wire  [NPIN-1:0] pin_raw = {ra_on_unwired_pin, cable_supply_above_uv_pin, bus_safe_zero_pin,
                              bus_above_uv_pin, bus_in_window_pin, supply_above_ov_pin,
                              supply_above_uv_pin};
  wire  [NPIN-1:0] pin_agree = ~(sync2_reg ^ sync3_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg   <= '0;
    end else if (ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (pin_agree & sync3_reg) | (~pin_agree & pin_reg);
    end
  end

  wire supply_uv_ok  = pin_reg[0];
  wire supply_ov_ok  = pin_reg[1];  // high means below overvoltage
  wire bus_window_ok = pin_reg[2];
  wire bus_uv_ok     = pin_reg[3];
  wire bus_zero      = pin_reg[4];
  wire cable_uv_ok   = pin_reg[5];
  wire ra_seen       = pin_reg[6];

  // configuration: stored defaults captured after reset, software may change
  // stored values land on the first enabled edge after reset; cfg_loaded_reg keeps
  // both enables off until then, so neither enable ever acts on a reset value
  logic       cfg_loaded_reg;
  logic       uv_chk_reg, ov_chk_reg, win_chk_reg, cdis_en_reg, cuv_sel_reg;
  logic [7:0] disch_time_reg;
  logic       bus_disch_en_reg;
  conn_state_t state_reg;
  logic       src_on_reg, snk_on_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_loaded_reg   <= 1'b0;
      uv_chk_reg       <= 1'b0;
      ov_chk_reg       <= 1'b0;
      win_chk_reg      <= 1'b1;
      cdis_en_reg      <= 1'b0;
      cuv_sel_reg      <= CABLE_UV_SEL_HIGH;
      disch_time_reg   <= BUS_DISCH_DEFAULT;
      bus_disch_en_reg <= 1'b1;
    end else if (ce) begin
      if (!cfg_loaded_reg) begin
        bus_disch_en_reg <= nvm_bus_disch_en;
        disch_time_reg   <= nvm_bus_disch_time;
        uv_chk_reg       <= nvm_supply_uv_check;
        ov_chk_reg       <= nvm_supply_ov_check;
        win_chk_reg      <= nvm_bus_window_check;
        cdis_en_reg      <= nvm_cable_disch_en;
        cfg_loaded_reg   <= 1'b1;
      end else begin
        if (sw_wr_disch_time) disch_time_reg <= sw_disch_time;
        if (sw_wr_checks) begin
          uv_chk_reg  <= sw_supply_uv_check;
          ov_chk_reg  <= sw_supply_ov_check;
          win_chk_reg <= sw_bus_window_check;
          cdis_en_reg <= sw_cable_disch_en;
        end
        if (sw_wr_cable_uv_sel) cuv_sel_reg <= sw_cable_uv_sel;
      end
    end
  end

  // state decode
  // state_reg is last cycle's state, so leaving an attached state is seen in the same cycle conn_state leaves it
  wire in_src_att = (conn_state == ST_ATTACHED_SRC) || (conn_state == ST_UNORIENT_DBG_SRC) ||
                    (conn_state == ST_ORIENT_DBG_SRC);
  wire in_snk_att = (conn_state == ST_ATTACHED_SNK) || (conn_state == ST_DBG_SNK);
  wire was_att    = (state_reg == ST_ATTACHED_SRC) || (state_reg == ST_UNORIENT_DBG_SRC) ||
                    (state_reg == ST_ORIENT_DBG_SRC) || (state_reg == ST_ATTACHED_SNK) ||
                    (state_reg == ST_DBG_SNK);
  wire was_src_att = (state_reg == ST_ATTACHED_SRC) || (state_reg == ST_UNORIENT_DBG_SRC) ||
                     (state_reg == ST_ORIENT_DBG_SRC);
  wire now_att    = in_src_att || in_snk_att;
  wire detach     = was_att && !now_att;
  wire enter_err  = (conn_state == ST_ERROR_RECOVERY) && (state_reg != ST_ERROR_RECOVERY);

  wire bus_valid  = win_chk_reg ? bus_window_ok : bus_uv_ok;
  wire supply_ok  = (!uv_chk_reg || supply_uv_ok) && (!ov_chk_reg || supply_ov_ok);

  // once on, the supply is no longer looked at; only the bus sense keeps it on
  // supply gates turn-on, bus sense keeps it on
  wire src_next = in_src_att && cfg_loaded_reg && (src_on_reg ? bus_valid : (supply_ok && bus_valid));
  wire snk_next = in_snk_att && cfg_loaded_reg && bus_valid;

  // the enables are registered so the pins never glitch on a decode hazard
  // registered enables from registered inputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= ST_UNATTACHED;
      src_on_reg <= 1'b0;
      snk_on_reg <= 1'b0;
    end else if (ce) begin
      state_reg  <= conn_state;
      src_on_reg <= src_next;
      snk_on_reg <= snk_next;
    end
  end

  // release to high impedance, drive low when on
  assign source_path_enable_n_out = 1'b0;
  assign source_path_enable_n_oe  = !src_on_reg;
  assign sink_path_enable_n_out   = 1'b0;
  assign sink_path_enable_n_oe    = !snk_on_reg;

  // combinational, so the state machine hears of the fault in the cycle before release
  // out of range after attach reports to state machine
  assign source_fault_to_recovery = src_on_reg && in_src_att && !bus_valid;
  assign sink_fault_to_unattached = snk_on_reg && in_snk_att && !bus_valid;
  // source attach only at safe zero volts
  assign source_attach_allowed    = bus_zero;

  // bus and cable discharge timers share one timer module each
  // a new event restarts a running timer, so repeated detaches stretch the discharge
  // 24-bit count: 255 steps of one millisecond and the 250 ms cable time both fit
  discharge_if bus_dif ();
  discharge_if cab_dif ();

  // discharge on detach or error entry when enabled
  assign bus_dif.start = ce && bus_disch_en_reg && (detach || enter_err);
  assign bus_dif.abort = 1'b0;
  assign bus_dif.duration_cycles = 24'(disch_time_reg * BUS_DISCH_UNIT_CYC);
  // cable discharge after sink detach in source mode only
  assign cab_dif.start = ce && cdis_en_reg && was_src_att && !now_att && (power_role != ROLE_SINK);
  assign cab_dif.abort = 1'b0;
  assign cab_dif.duration_cycles = 24'(CABLE_DISCH_COUNT);

  discharge_timer u_bus_timer (.clock(clock), .nrst(nrst), .ce(ce), .dif(bus_dif));
  discharge_timer u_cab_timer (.clock(clock), .nrst(nrst), .ce(ce), .dif(cab_dif));

  assign bus_discharge_on   = bus_dif.active;
  assign cable_discharge_on = cab_dif.active;
  assign cable_uv_sel       = cuv_sel_reg;

  // the supply goes to the pin opposite the CC wire, never to the wired one
  // cable supply conditions
  wire cable_ok = (power_role != ROLE_SINK) && cable_switch_en && in_src_att && ra_seen && cable_uv_ok;
  logic cab1_reg, cab2_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cab1_reg <= 1'b0;
      cab2_reg <= 1'b0;
    end else if (ce) begin
      cab1_reg <= cable_ok && cc_wire_is_cc2;
      cab2_reg <= cable_ok && !cc_wire_is_cc2;
    end
  end
  assign cable_supply_cc1 = cab1_reg;
  assign cable_supply_cc2 = cab2_reg;

  a_src_needs_state: assert property (@(posedge clock) disable iff (!nrst)
    (!source_path_enable_n_oe && $past(ce)) |-> $past(in_src_att))
    else $error("source enable driven outside attached source");
  a_src_supply_gate: assert property (@(posedge clock) disable iff (!nrst)
    ($rose(src_on_reg)) |-> $past(supply_ok && bus_valid))
    else $error("source enable rose without supply valid");
  a_src_release: assert property (@(posedge clock) disable iff (!nrst)
    (ce && !bus_valid) |=> source_path_enable_n_oe)
    else $error("source enable not released on invalid bus");
  a_snk_valid: assert property (@(posedge clock) disable iff (!nrst)
    (ce && in_snk_att && bus_valid && cfg_loaded_reg) |=> !sink_path_enable_n_oe)
    else $error("sink enable not driven when valid");
  a_snk_release: assert property (@(posedge clock) disable iff (!nrst)
    (ce && !in_snk_att) |=> sink_path_enable_n_oe)
    else $error("sink enable not released");
  a_src_hold: assert property (@(posedge clock) disable iff (!nrst)
    (ce && src_on_reg && in_src_att && bus_valid) |=> src_on_reg)
    else $error("source enable dropped while valid");
  a_disch_start: assert property (@(posedge clock) disable iff (!nrst)
    (ce && bus_disch_en_reg && detach && disch_time_reg != 8'h00) |=> bus_discharge_on)
    else $error("bus discharge missing after detach");
  a_cable_sink: assert property (@(posedge clock) disable iff (!nrst)
    $past(ce && power_role == ROLE_SINK) |-> !(cable_supply_cc1 || cable_supply_cc2))
    else $error("cable supply given in sink role");
  a_cable_one_pin: assert property (@(posedge clock) disable iff (!nrst)
    !(cable_supply_cc1 && cable_supply_cc2))
    else $error("cable supply on both pins");

  // gating of turn-on, faults, cable supply and discharge
  a_src_supply_block: assert property (@(posedge clock) disable iff (!nrst)
    (ce && !src_on_reg && !supply_ok) |=> source_path_enable_n_oe)
    else $error("source enable rose with supply invalid");
  a_bus_takes_over: assert property (@(posedge clock) disable iff (!nrst)
    (ce && src_on_reg && in_src_att && bus_valid && !supply_ok) |=> src_on_reg)
    else $error("source enable dropped on supply after turn-on");
  a_snk_ignores_supply: assert property (@(posedge clock) disable iff (!nrst)
    (ce && cfg_loaded_reg && in_snk_att && bus_valid && !supply_ok) |=> !sink_path_enable_n_oe)
    else $error("sink enable blocked by supply check");
  a_fault_release: assert property (@(posedge clock) disable iff (!nrst)
    (ce && (source_fault_to_recovery || sink_fault_to_unattached)) |=>
      (source_path_enable_n_oe && sink_path_enable_n_oe))
    else $error("path not released after bus fault");
  a_cable_gate: assert property (@(posedge clock) disable iff (!nrst)
    $rose(cable_supply_cc1 || cable_supply_cc2) |-> $past(cable_switch_en && ra_seen && cable_uv_ok))
    else $error("cable supply rose without its conditions");
  a_cable_disch_role: assert property (@(posedge clock) disable iff (!nrst)
    $rose(cable_discharge_on) |-> $past(power_role != ROLE_SINK && was_src_att))
    else $error("cable discharge outside source detach");
  a_disch_stays_off: assert property (@(posedge clock) disable iff (!nrst)
    (ce && !bus_disch_en_reg && !bus_discharge_on) |=> !bus_discharge_on)
    else $error("bus discharge ran while disabled");
endmodule
`default_nettype wire

// ===== verification/bus_port_model.sv
// Purpose: far side model, the port's bus sense comparators
// Assumes: the bench commands the bus level as a two-bit code
// Notes:   0 zero volts, 1 under the window, 2 inside it, 3 over it
`default_nettype none
module bus_port_model (
  input  wire logic [1:0] level,
  output logic            in_window,
  output logic            above_uv,
  output logic            safe_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  // over-window still reads above undervoltage, so the uv-only check passes it
  assign safe_zero = (level == 2'h0);
  assign above_uv  = (level != 2'h0);
  assign in_window = (level == 2'h2);
endmodule
`default_nettype wire

// ===== verification/power_path_control_tb_top.sv
// Purpose: self-checking bench for the bus and cable power path control
// Assumes: 40 MHz clock, short cable discharge count, one ms bus discharge
// Notes:   monitors are set while unattached, so they have settled at attach
`default_nettype none
module power_path_control_tb_top import power_path_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DC = 50;
  logic        clock, nrst, ce, cc_wire_is_cc2, supply_above_uv_pin, supply_above_ov_pin;
  logic        bus_in_window_pin, bus_above_uv_pin, bus_safe_zero_pin, cable_supply_above_uv_pin;
  logic        ra_on_unwired_pin, nvm_bus_disch_en, nvm_supply_uv_check, nvm_supply_ov_check;
  logic        nvm_bus_window_check, nvm_cable_disch_en, sw_wr_disch_time, sw_wr_checks;
  logic        sw_supply_uv_check, sw_supply_ov_check, sw_bus_window_check, sw_cable_disch_en;
  logic        sw_cable_uv_sel, sw_wr_cable_uv_sel, cable_switch_en, source_path_enable_n_out;
  logic        source_path_enable_n_oe, sink_path_enable_n_out, sink_path_enable_n_oe;
  logic        bus_discharge_on, cable_supply_cc1, cable_supply_cc2, cable_discharge_on, cable_uv_sel;
  logic        source_fault_to_recovery, sink_fault_to_unattached, source_attach_allowed;
  logic        uvc, ovc, winc, sup, src, cab;
  logic [7:0]  nvm_bus_disch_time, sw_disch_time;
  logic [1:0]  level;
  logic [31:0] r;
  conn_state_t conn_state, st;
  power_role_t power_role;
  int          fails, comparisons, seed, n;

  power_path_control #(.CABLE_DISCH_COUNT(DC)) uut (
    .clock, .nrst, .ce, .conn_state, .power_role, .cc_wire_is_cc2, .supply_above_uv_pin,
    .supply_above_ov_pin, .bus_in_window_pin, .bus_above_uv_pin, .bus_safe_zero_pin,
    .cable_supply_above_uv_pin, .ra_on_unwired_pin, .nvm_bus_disch_en, .nvm_bus_disch_time,
    .nvm_supply_uv_check, .nvm_supply_ov_check, .nvm_bus_window_check, .nvm_cable_disch_en,
    .sw_wr_disch_time, .sw_disch_time, .sw_wr_checks, .sw_supply_uv_check, .sw_supply_ov_check,
    .sw_bus_window_check, .sw_cable_disch_en, .sw_cable_uv_sel, .sw_wr_cable_uv_sel,
    .cable_switch_en, .source_path_enable_n_out, .source_path_enable_n_oe, .sink_path_enable_n_out,
    .sink_path_enable_n_oe, .bus_discharge_on, .cable_supply_cc1, .cable_supply_cc2,
    .cable_discharge_on, .cable_uv_sel, .source_fault_to_recovery, .sink_fault_to_unattached,
    .source_attach_allowed);
  bus_port_model far (.level, .in_window(bus_in_window_pin), .above_uv(bus_above_uv_pin),
    .safe_zero(bus_safe_zero_pin));

  always #12.5 clock = ~clock;

  // checks happen at the edge itself, before that edge's updates land
  task automatic step(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic chk_span(input int got, input int exp, input string msg);
    comparisons++;
    if (got < exp - 2 || got > exp + 1) begin
      fails++;
      $display("wrong value at %0t: %s lasted %0d", $time, msg, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic bus_ok(input logic [1:0] lv);
    return winc ? (lv == 2'h2) : (lv != 2'h0);
  endfunction

  task automatic write_checks(input logic uv, input logic ov, input logic win, input logic cd);
    {sw_supply_uv_check, sw_supply_ov_check, sw_bus_window_check, sw_cable_disch_en} <= {uv, ov, win, cd};
    sw_wr_checks <= 1'b1;
    step(1);
    sw_wr_checks <= 1'b0;
    {uvc, ovc, winc} = {uv, ov, win};
  endtask

  task automatic detach(input conn_state_t from);
    conn_state <= from;
    step(3);
    conn_state <= ST_UNATTACHED;
    step(2);
  endtask

  // attach with good monitors, drop the supply, then push the bus out of range
  task automatic fault_case(input conn_state_t s);
    logic seen;
    seen = 1'b0;
    conn_state <= ST_UNATTACHED;
    level <= 2'h2;
    supply_above_uv_pin <= 1'b1;
    step(8);
    conn_state <= s;
    step(4);
    chk(s == ST_ATTACHED_SRC ? source_path_enable_n_oe : sink_path_enable_n_oe, 1'b0, "enable on");
    supply_above_uv_pin <= 1'b0;
    step(8);
    chk(s == ST_ATTACHED_SRC ? source_path_enable_n_oe : sink_path_enable_n_oe, 1'b0, "held");
    level <= 2'h1;
    repeat (8) begin
      step(1);
      seen = seen | (s == ST_ATTACHED_SRC ? source_fault_to_recovery : sink_fault_to_unattached);
    end
    chk(s == ST_ATTACHED_SRC ? source_path_enable_n_oe : sink_path_enable_n_oe, 1'b1, "released");
    chk(seen, 1'b1, "fault flag");
  endtask

  // watchdog sized well past the one long bus discharge
  initial begin
    #(25 * 60000);
    fails++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h0000_68e8;
    {clock, nrst, ce, cc_wire_is_cc2, sw_wr_disch_time, sw_wr_checks, sw_wr_cable_uv_sel} = 7'h00;
    {supply_above_uv_pin, supply_above_ov_pin, cable_supply_above_uv_pin, ra_on_unwired_pin} = 4'hf;
    {nvm_bus_disch_en, nvm_supply_uv_check, nvm_supply_ov_check, nvm_bus_window_check} = 4'hf;
    {nvm_cable_disch_en, sw_supply_uv_check, sw_supply_ov_check, sw_bus_window_check} = 4'h0;
    {sw_cable_disch_en, sw_cable_uv_sel, cable_switch_en} = 3'h1;
    {uvc, ovc, winc} = 3'h7;
    {nvm_bus_disch_time, sw_disch_time, level} = {8'h01, 8'h00, 2'h0};
    conn_state = ST_UNATTACHED;
    power_role = ROLE_SOURCE;
    ce = 1'b1;
    step(6);
    nrst <= 1'b1;
    step(2);
    chk(source_path_enable_n_oe, 1'b1, "src released");
    chk(sink_path_enable_n_oe, 1'b1, "snk released");
    chk(cable_uv_sel, CABLE_UV_SEL_HIGH, "uv select default");
    chk(source_path_enable_n_out, 1'b0, "src drive level");
    chk(sink_path_enable_n_out, 1'b0, "snk drive level");
    chk(bus_discharge_on, 1'b0, "no discharge after reset");
    // recovery entry while idle, so the discharge seen here is its own
    conn_state <= ST_ERROR_RECOVERY;
    step(2);
    chk(bus_discharge_on, 1'b1, "discharge on recovery");
    fault_case(ST_ATTACHED_SRC);
    fault_case(ST_ATTACHED_SNK);
    detach(ST_ATTACHED_SRC);
    chk(bus_discharge_on, 1'b1, "discharge on detach");
    chk(cable_discharge_on, 1'b0, "cable discharge off by default");
    n = 0;
    while (bus_discharge_on === 1'b1 && n < 50000) begin
      step(1);
      n++;
    end
    chk_span(n, BUS_DISCH_UNIT_CYC, "bus discharge");
    sw_wr_disch_time <= 1'b1;
    step(1);
    sw_wr_disch_time <= 1'b0;
    detach(ST_ATTACHED_SRC);
    chk(bus_discharge_on, 1'b0, "zero duration");
    // random monitor levels, first window check on, then uv-only with ov check
    for (int j = 0; j < 2; j++) begin
      if (j == 1) write_checks(1'b0, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 30; i++) begin
        r = $random(seed);
        conn_state <= ST_UNATTACHED;
        step(8);
        {supply_above_uv_pin, supply_above_ov_pin, cable_supply_above_uv_pin} <= r[2:0];
        {ra_on_unwired_pin, cable_switch_en, cc_wire_is_cc2, level} <= r[7:3];
        power_role <= (r[9:8] == 2'h3) ? ROLE_DUAL : power_role_t'(r[9:8]);
        st = conn_state_t'({1'b0, r[12:10]});
        step(6);
        conn_state <= st;
        step(4);
        sup = (!uvc || supply_above_uv_pin) && (!ovc || supply_above_ov_pin);
        src = st inside {ST_ATTACHED_SRC, ST_UNORIENT_DBG_SRC, ST_ORIENT_DBG_SRC};
        cab = power_role != ROLE_SINK && cable_switch_en && src && ra_on_unwired_pin && cable_supply_above_uv_pin;
        chk(source_path_enable_n_oe, !(src && sup && bus_ok(level)), "src enable");
        chk(sink_path_enable_n_oe, !(st inside {ST_ATTACHED_SNK, ST_DBG_SNK} && bus_ok(level)), "snk");
        chk(cable_supply_cc1, cab && cc_wire_is_cc2, "cable cc1");
        chk(cable_supply_cc2, cab && !cc_wire_is_cc2, "cable cc2");
        chk(source_attach_allowed, level == 2'h0, "attach allowed");
      end
    end
    write_checks(1'b0, 1'b1, 1'b0, 1'b1);
    power_role <= ROLE_SOURCE;
    detach(ST_ATTACHED_SRC);
    chk(cable_discharge_on, 1'b1, "cable discharge on");
    n = 0;
    while (cable_discharge_on === 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk_span(n, DC, "cable discharge");
    sw_cable_uv_sel <= CABLE_UV_SEL_LOW;
    sw_wr_cable_uv_sel <= 1'b1;
    step(1);
    sw_wr_cable_uv_sel <= 1'b0;
    step(2);
    chk(cable_uv_sel, CABLE_UV_SEL_LOW, "uv select low");
    // second reset mid-run with stored discharge and window check off
    {nvm_bus_disch_en, nvm_bus_window_check, nrst} <= 3'h0;
    step(2);
    nrst <= 1'b1;
    winc = 1'b0;
    step(3);
    chk(cable_uv_sel, CABLE_UV_SEL_HIGH, "uv select after reset");
    detach(ST_ATTACHED_SRC);
    chk(bus_discharge_on, 1'b0, "stored discharge off");
    level <= 2'h3;
    conn_state <= ST_ATTACHED_SNK;
    step(8);
    chk(sink_path_enable_n_oe, !bus_ok(2'h3), "uv only check");
    // clock enable low: the bus falls to zero but nothing may move until it returns
    ce <= 1'b0;
    level <= 2'h0;
    step(8);
    chk(sink_path_enable_n_oe, 1'b0, "frozen by clock enable");
    ce <= 1'b1;
    step(8);
    chk(sink_path_enable_n_oe, 1'b1, "released after enable");
    tally_and_finish();
  end
endmodule
`default_nettype wire
